// file: e1_perf_counters_irq_masks.sv
/*
 * E1 per-framer monitoring: interrupt masks, sticky status, interval
 * timer and saturating error counters with interval snapshots.
 * Assumes all inputs are synchronous to I_CORE_CLK and that the line
 * symbol strobe fires once per received bit.
 */
// Our own choice: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "e1pc_defs.svh"

// What this block does
// - Receive mask: bit7..0 sig ones, dist MF alarm, sig zeros, slip, ua1, RA, CL, LOS.
// - Second mask: CAS MF, align, tx MF, second timer, tx align, clk loss, CRC MF, slip.
// - All counters snapshot together each second, or 62.5 ms with fast select.
// - Readable counts hold the previous full interval until next update.
// - Every error counter stops at its maximum, never wraps.
// - Violation counter counts bipolar violations when type select is 0.
// - With HDB3 enabled, substitution-code violations are not counted.
// - Type select 1 counts code violations: same-polarity consecutive BPVs.
// - Violation counter never stops for sync loss, saturates at 65535.
// - Violation count read as high byte at 0x00, low byte at 0x01.
// - 10-bit CRC4 error count: bits 9:8 at 0x02, bits 7:0 at 0x03.
// - CRC4 and E-bit counting halts on FAS or CRC4 MF sync loss.
// - Upper six bits at 0x02 read the FAS error count's top six bits.
// - 10-bit E-bit counter: zero E-bits in frames 13 and 15.
// - Interval timer runs off receive bits, sets the second status flag.
module e1_perf_counters_irq_masks
    import e1pc_pkg::*;
#(
    parameter int unsigned BITS_PER_SEC = `E1PC_BITS_PER_SEC
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic i_ce,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire line_sym_t i_line,
    input wire sync_info_t i_sync,
    input wire logic [7:0] i_rx_events,
    input wire logic [7:0] i_ft_events,
    output logic o_irq
);

    localparam int unsigned FAST_BITS = BITS_PER_SEC / `E1PC_FAST_DIV;
    localparam logic [21:0] SEC_LAST = 22'(BITS_PER_SEC - 1);
    localparam logic [21:0] FAST_LAST = 22'(FAST_BITS - 1);

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    logic [7:0] rx_mask_q;
    logic [7:0] ft_mask_q;
    logic [7:0] ctrl_raw_q;
    ctrl_t ctrl;
    logic [7:0] rx_sts_q;
    logic [7:0] ft_sts_q;

    assign ctrl.fast_interval_select = ctrl_raw_q[`E1PC_CTRL_FAST_BIT];
    assign ctrl.violation_type_select = ctrl_raw_q[`E1PC_CTRL_VTYPE_BIT];
    assign ctrl.rx_hdb3_enable = ctrl_raw_q[`E1PC_CTRL_HDB3_BIT];

    wire wr_rx_mask = i_wr && (i_addr == `E1PC_OFF_RX_MASK);
    wire wr_ft_mask = i_wr && (i_addr == `E1PC_OFF_FT_MASK);
    wire wr_ctrl = i_wr && (i_addr == `E1PC_OFF_CTRL);
    wire wr_rx_sts = i_wr && (i_addr == `E1PC_OFF_RX_STATUS);
    wire wr_ft_sts = i_wr && (i_addr == `E1PC_OFF_FT_STATUS);

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rx_mask_q <= `E1PC_MASK_RST;
            ft_mask_q <= `E1PC_MASK_RST;
            ctrl_raw_q <= `E1PC_CTRL_RST;
        end else if (i_ce) begin
            if (wr_rx_mask) begin
                rx_mask_q <= i_wdata;
            end
            if (wr_ft_mask) begin
                ft_mask_q <= i_wdata;
            end
            if (wr_ctrl) begin
                ctrl_raw_q <= i_wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Interval timer
    // ------------------------------------------------------------
    logic [21:0] tmr_q;
    logic tick;

    // Counts received bits, so the interval follows the line clock
    assign tick = i_line.stb && (tmr_q == (ctrl.fast_interval_select ?
                  FAST_LAST : SEC_LAST));

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            tmr_q <= 22'h0;
        end else if (i_ce && i_line.stb) begin
            tmr_q <= tick ? 22'h0 : tmr_q + 22'h1;
        end
    end

    // ------------------------------------------------------------
    // Sticky status and interrupt
    // ------------------------------------------------------------
    logic [7:0] ft_evt;

    always_comb begin
        ft_evt = i_ft_events;
        ft_evt[`E1PC_SEC_FLAG_BIT] = tick;
    end

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rx_sts_q <= 8'h00;
            ft_sts_q <= 8'h00;
        end else if (i_ce) begin
            rx_sts_q <= (rx_sts_q & ~(wr_rx_sts ? i_wdata : 8'h00))
                        | i_rx_events;
            ft_sts_q <= (ft_sts_q & ~(wr_ft_sts ? i_wdata : 8'h00))
                        | ft_evt;
        end
    end

    wire pend_any = |(rx_sts_q & rx_mask_q) | |(ft_sts_q & ft_mask_q);

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            o_irq <= 1'b0;
        end else if (i_ce) begin
            o_irq <= pend_any;
        end
    end

    // ------------------------------------------------------------
    // Violation detection
    // ------------------------------------------------------------
    logic last_pol_q;
    logic last_bpv_pol_q;
    logic have_bpv_q;
    logic have_mark_q;
    logic [1:0] zeros_q;
    logic mark;
    logic bpv;
    logic hdb3_sub;
    logic cv;
    logic viol;

    assign mark = i_line.stb && (i_line.pos || i_line.neg);
    // No mark since reset means nothing for the first mark to repeat
    assign bpv = mark && have_mark_q && (i_line.pos == last_pol_q);
    // 000V and B00V both put two zeros right before the V
    assign hdb3_sub = (zeros_q == 2'b00);
    assign cv = bpv && have_bpv_q && (i_line.pos == last_bpv_pol_q);
    assign viol = ctrl.violation_type_select ? cv
                : (bpv && !(ctrl.rx_hdb3_enable && hdb3_sub));

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            last_pol_q <= 1'b0;
            have_mark_q <= 1'b0;
            last_bpv_pol_q <= 1'b0;
            have_bpv_q <= 1'b0;
            zeros_q <= 2'b11;
        end else if (i_ce && i_line.stb) begin
            zeros_q <= {zeros_q[0], mark};
            if (mark) begin
                last_pol_q <= i_line.pos;
                have_mark_q <= 1'b1;
            end
            if (bpv) begin
                last_bpv_pol_q <= i_line.pos;
                have_bpv_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Running counters and snapshots
    // ------------------------------------------------------------
    logic in_sync;
    logic crc_evt;
    logic eb_evt;
    logic fas_evt;
    logic [15:0] vc_run_q;
    logic [15:0] vc_snap_q;
    logic [9:0] crc_run_q;
    logic [9:0] crc_snap_q;
    logic [9:0] eb_run_q;
    logic [9:0] eb_snap_q;
    logic [11:0] fas_run_q;
    logic [11:0] fas_snap_q;

    assign in_sync = !i_sync.fas_lost && !i_sync.crc_mf_lost;
    assign crc_evt = in_sync && i_sync.crc_err;
    assign eb_evt = in_sync && i_sync.ebit_stb && !i_sync.ebit_val
        && ((i_sync.frame_num == `E1PC_EBIT_FRAME_A)
        || (i_sync.frame_num == `E1PC_EBIT_FRAME_B));
    assign fas_evt = !i_sync.fas_lost && i_sync.fas_err;

    // Running count restarts at the event of the boundary cycle itself
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            vc_run_q <= 16'h0;
            vc_snap_q <= 16'h0;
        end else if (i_ce) begin
            if (tick) begin
                vc_snap_q <= vc_run_q;
                vc_run_q <= {15'h0, viol};
            end else if (viol && vc_run_q != `E1PC_VC_MAX) begin
                vc_run_q <= vc_run_q + 16'h1;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            crc_run_q <= 10'h0;
            crc_snap_q <= 10'h0;
        end else if (i_ce) begin
            if (tick) begin
                crc_snap_q <= crc_run_q;
                crc_run_q <= {9'h0, crc_evt};
            end else if (crc_evt && crc_run_q != `E1PC_C10_MAX) begin
                crc_run_q <= crc_run_q + 10'h1;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            eb_run_q <= 10'h0;
            eb_snap_q <= 10'h0;
        end else if (i_ce) begin
            if (tick) begin
                eb_snap_q <= eb_run_q;
                eb_run_q <= {9'h0, eb_evt};
            end else if (eb_evt && eb_run_q != `E1PC_C10_MAX) begin
                eb_run_q <= eb_run_q + 10'h1;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            fas_run_q <= 12'h0;
            fas_snap_q <= 12'h0;
        end else if (i_ce) begin
            if (tick) begin
                fas_snap_q <= fas_run_q;
                fas_run_q <= {11'h0, fas_evt};
            end else if (fas_evt && fas_run_q != `E1PC_FAS_MAX) begin
                fas_run_q <= fas_run_q + 12'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    logic [7:0] rd_mux;

    // Unmapped addresses read as zero
    always_comb begin
        if (i_addr == `E1PC_OFF_VC_HI) begin
            rd_mux = vc_snap_q[15:8];
        end else if (i_addr == `E1PC_OFF_VC_LO) begin
            rd_mux = vc_snap_q[7:0];
        end else if (i_addr == `E1PC_OFF_CRC_HI) begin
            rd_mux = {fas_snap_q[11:6], crc_snap_q[9:8]};
        end else if (i_addr == `E1PC_OFF_CRC_LO) begin
            rd_mux = crc_snap_q[7:0];
        end else if (i_addr == `E1PC_OFF_EB_SHARED) begin
            rd_mux = {fas_snap_q[5:0], eb_snap_q[9:8]};
        end else if (i_addr == `E1PC_OFF_EB_LO) begin
            rd_mux = eb_snap_q[7:0];
        end else if (i_addr == `E1PC_OFF_RX_STATUS) begin
            rd_mux = rx_sts_q;
        end else if (i_addr == `E1PC_OFF_FT_STATUS) begin
            rd_mux = ft_sts_q;
        end else if (i_addr == `E1PC_OFF_RX_MASK) begin
            rd_mux = rx_mask_q;
        end else if (i_addr == `E1PC_OFF_FT_MASK) begin
            rd_mux = ft_mask_q;
        end else if (i_addr == `E1PC_OFF_CTRL) begin
            rd_mux = ctrl_raw_q;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Data holds only in the cycle after the strobe
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            o_rdata <= 8'h00;
        end else if (i_ce) begin
            o_rdata <= i_rd ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    irq_gating_a: assert property (
        i_ce && pend_any |=> o_irq)
        else $error("irq low with unmasked status");

    irq_quiet_a: assert property (
        i_ce && !pend_any |=> !o_irq)
        else $error("irq high with all status masked");

    snap_hold_a: assert property (
        !(i_ce && tick) |=> $stable(vc_snap_q) && $stable(crc_snap_q)
            && $stable(eb_snap_q) && $stable(fas_snap_q))
        else $error("snapshot moved between boundaries");

    snap_load_a: assert property (
        i_ce && tick |=> vc_snap_q == $past(vc_run_q)
            && vc_run_q == 16'($past(viol)))
        else $error("boundary transfer wrong");

    vc_sat_a: assert property (
        i_ce && !tick && vc_run_q == `E1PC_VC_MAX |=>
            vc_run_q == `E1PC_VC_MAX)
        else $error("violation counter wrapped");

    vc_count_a: assert property (
        i_ce && !tick && viol && vc_run_q != `E1PC_VC_MAX |=>
            vc_run_q == $past(vc_run_q) + 16'h1)
        else $error("violation not counted");

    crc_halt_a: assert property (
        i_ce && !tick && !in_sync |=> $stable(crc_run_q)
            && $stable(eb_run_q))
        else $error("crc or ebit counted out of sync");

    sec_flag_a: assert property (
        i_ce && tick |=> ft_sts_q[`E1PC_SEC_FLAG_BIT])
        else $error("second flag not set on interval");

    mask_write_a: assert property (
        i_ce && wr_rx_mask ##1 i_ce && i_rd
            && i_addr == `E1PC_OFF_RX_MASK |=>
            o_rdata == $past(i_wdata, 2))
        else $error("receive mask readback wrong");

    hdb3_skip_a: assert property (
        i_ce && tick == 1'b0 && bpv && ctrl.rx_hdb3_enable
            && !ctrl.violation_type_select && hdb3_sub
            && vc_run_q != `E1PC_VC_MAX |=> $stable(vc_run_q))
        else $error("hdb3 substitution counted");

    tick_cov: cover property (i_ce && tick);
    irq_cov: cover property (!o_irq ##1 o_irq);
    cv_cov: cover property (i_ce && cv && ctrl.violation_type_select);
    vc_sat_cov: cover property (vc_run_q == `E1PC_VC_MAX);
    hdb3_cov: cover property (i_ce && bpv && ctrl.rx_hdb3_enable && hdb3_sub);

endmodule : e1_perf_counters_irq_masks
`default_nettype wire

// file: e1pc_defs.svh
/*
 * Offsets, field positions, reset values and counts for the E1
 * performance counter and interrupt mask bank.
 * Assumes an 8-bit register port and a 2.048 Mbit/s receive line.
 */
`ifndef E1PC_DEFS_SVH
`define E1PC_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define E1PC_OFF_VC_HI 8'h00
`define E1PC_OFF_VC_LO 8'h01
`define E1PC_OFF_CRC_HI 8'h02
`define E1PC_OFF_CRC_LO 8'h03
`define E1PC_OFF_EB_SHARED 8'h04
`define E1PC_OFF_EB_LO 8'h05
`define E1PC_OFF_RX_STATUS 8'h06
`define E1PC_OFF_FT_STATUS 8'h07
`define E1PC_OFF_RX_MASK 8'h16
`define E1PC_OFF_FT_MASK 8'h17
`define E1PC_OFF_CTRL 8'h1a

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define E1PC_CTRL_FAST_BIT 7
`define E1PC_CTRL_VTYPE_BIT 6
`define E1PC_CTRL_HDB3_BIT 2
`define E1PC_CTRL_RST 8'h00
`define E1PC_MASK_RST 8'h00
`define E1PC_SEC_FLAG_BIT 4

// ----------------------------------------------------------------
// Counter limits and timing
// ----------------------------------------------------------------
`define E1PC_VC_MAX 16'hffff
`define E1PC_C10_MAX 10'h3ff
`define E1PC_FAS_MAX 12'hfff
`define E1PC_BITS_PER_SEC 2048000
`define E1PC_FAST_DIV 16
`define E1PC_EBIT_FRAME_A 4'hd
`define E1PC_EBIT_FRAME_B 4'hf

`endif

// file: e1pc_pkg.sv
/*
 * Types shared by the E1 performance counter bank.
 * Assumes e1pc_defs.svh carries the numbers.
 */
package e1pc_pkg;

    // One received line symbol, valid when stb is high
    typedef struct packed {
        logic stb;
        logic pos;
        logic neg;
    } line_sym_t;

    // Framer synchroniser and per-frame error strobes
    typedef struct packed {
        logic fas_lost;
        logic crc_mf_lost;
        logic fas_err;
        logic crc_err;
        logic ebit_stb;
        logic ebit_val;
        logic [3:0] frame_num;
    } sync_info_t;

    typedef struct packed {
        logic fast_interval_select;
        logic violation_type_select;
        logic rx_hdb3_enable;
    } ctrl_t;

endpackage : e1pc_pkg

// file: e1_line_model.sv
/*
 * Receive line path model: one line symbol every other clock, a
 * running CRC4 frame number with E-bits, error strobes and sync levels.
 * Assumes the bench chooses symbol, E-bit, error and loss values.
 */
`timescale 1ns/1ps
`default_nettype none
module e1_line_model
    import e1pc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [1:0] i_sym,
    input wire logic i_eval,
    input wire logic i_crc_err,
    input wire logic i_fas_err,
    input wire logic [1:0] i_lost,
    output var line_sym_t o_line,
    output var sync_info_t o_sync
);
    logic ph_q;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ph_q <= 1'b0;
            o_line <= '0;
            o_sync <= '0;
        end else begin
            ph_q <= ~ph_q;
            o_line.stb <= ph_q;
            // Idle symbol lines flip so a stale value is never trusted
            o_line.pos <= ph_q ? i_sym[1] : ~o_line.pos;
            o_line.neg <= ph_q ? i_sym[0] : ~o_line.neg;
            o_sync.ebit_stb <= ph_q;
            o_sync.ebit_val <= ph_q ? i_eval : ~o_sync.ebit_val;
            if (ph_q) begin
                o_sync.frame_num <= o_sync.frame_num + 4'h1;
            end
            o_sync.crc_err <= i_crc_err;
            o_sync.fas_err <= i_fas_err;
            {o_sync.fas_lost, o_sync.crc_mf_lost} <= i_lost;
        end
    end
endmodule : e1_line_model
`default_nettype wire

// file: e1_perf_counters_irq_masks_tb_top.sv
/*
 * Self-checking bench for the E1 counter and interrupt mask bank.
 * Assumes e1_line_model feeds the line side; interval shortened.
 */
`timescale 1ns/1ps
`default_nettype none
`include "e1pc_defs.svh"
module e1_perf_counters_irq_masks_tb_top;
    import e1pc_pkg::*;
    localparam int BPS = 640;
    // ctrl, zero share of 16, loss toggling, constant CRC errors
    localparam int CFG [6][4] = '{'{0, 4, 0, 0}, '{4, 12, 0, 0},
        '{64, 4, 0, 0}, '{0, 4, 1, 0}, '{128, 4, 0, 0}, '{0, 0, 0, 1}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic rd_s = 1'b0;
    logic wr_s = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rx_ev = 8'h00;
    logic [7:0] ft_ev = 8'h00;
    logic [7:0] ctrl = 8'h00;
    logic [7:0] rdata;
    logic irq;
    logic [1:0] sym = 2'b00;
    logic [1:0] lost = 2'b00;
    logic eval = 1'b1;
    logic crc_e = 1'b0;
    logic fas_e = 1'b0;
    line_sym_t line;
    sync_info_t sync;
    int zb = 4;
    int lost_en = 0;
    int sat = 0;
    int nlen = BPS;
    int seed = 98853;
    int mismatches = 0;
    int total_checks = 0;
    int ticks = 0;
    int nbit;
    logic [15:0] run [4];
    logic [15:0] snap [4];
    logic [15:0] mx [4] = '{`E1PC_VC_MAX, {6'h00, `E1PC_C10_MAX},
        {6'h00, `E1PC_C10_MAX}, {4'h0, `E1PC_FAS_MAX}};
    logic [1:0] lastpol;
    logic [1:0] lastbpv;
    logic [1:0] z;

    e1_perf_counters_irq_masks #(.BITS_PER_SEC(BPS))
        e1_perf_counters_irq_masks_i (.I_CORE_CLK(clk), .I_RST(rst),
        .i_ce(ce), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s),
        .i_rd(rd_s), .o_rdata(rdata), .i_line(line), .i_sync(sync),
        .i_rx_events(rx_ev), .i_ft_events(ft_ev), .o_irq(irq));

    e1_line_model e1_line_model_i (.i_clk(clk), .i_rst(rst), .i_sym(sym),
        .i_eval(eval), .i_crc_err(crc_e), .i_fas_err(fas_e),
        .i_lost(lost), .o_line(line), .o_sync(sync));

    initial begin
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin : stim
        logic [31:0] r;
        r = $random(seed);
        sym <= (r[3:0] < zb) ? 2'b00 : {r[4], ~r[4]};
        crc_e <= sat != 0 || r[7:5] == 3'h0;
        fas_e <= r[8];
        eval <= r[9];
        if (lost_en == 0) lost <= 2'b00;
        else if (r[15:12] == 4'h0) lost <= r[11:10];
    end

    // Reference counts, built from what the design samples
    always @(posedge clk) begin : mon
        logic [15:0] ev [4];
        logic [1:0] p;
        logic mark, bpv, ok, tick;
        if (rst) begin
            nbit = 0;
            lastpol = 2'd0;
            lastbpv = 2'd0;
            z = 2'd0;
            foreach (run[k]) begin
                run[k] = 16'h0000;
                snap[k] = 16'h0000;
            end
        end else begin
            mark = line.pos | line.neg;
            p = line.pos ? 2'd1 : 2'd2;
            bpv = line.stb && mark && lastpol == p;
            ok = !sync.fas_lost && !sync.crc_mf_lost;
            ev[0] = ctrl[6] ? 16'(bpv && lastbpv == p)
                : 16'(bpv && !(ctrl[2] && z == 2'b11));
            ev[1] = 16'(sync.crc_err && ok);
            ev[2] = 16'(sync.ebit_stb && !sync.ebit_val && ok
                && sync.frame_num inside {4'hd, 4'hf});
            ev[3] = 16'(sync.fas_err && !sync.fas_lost);
            if (line.stb) begin
                lastpol = mark ? p : lastpol;
                lastbpv = bpv ? p : lastbpv;
                z = {z[0], !mark};
                nbit++;
            end
            tick = line.stb && nbit % nlen == 0;
            foreach (run[k]) begin
                if (tick) begin
                    snap[k] = run[k];
                    run[k] = ev[k];
                end else if ({1'b0, run[k]} + ev[k] > mx[k]) begin
                    run[k] = mx[k];
                end else begin
                    run[k] = run[k] + ev[k];
                end
            end
            if (tick) ticks++;
        end
    end

    function automatic logic [7:0] exp_b(input int a);
        case (a)
            0: return snap[0][15:8];
            1: return snap[0][7:0];
            2: return {snap[3][11:6], snap[1][9:8]};
            3: return snap[1][7:0];
            4: return {snap[3][5:0], snap[2][9:8]};
            default: return snap[2][7:0];
        endcase
    endfunction : exp_b

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic irq_is(input logic v);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, v}, "irq level");
    endtask : irq_is

    task automatic wait_tick();
        int t0 = ticks;
        int n = 0;
        while (ticks == t0 && n < 4 * BPS) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (ticks == t0) chk(8'h00, 8'h01, "no interval tick");
    endtask : wait_tick

    task automatic regs();
        logic [7:0] d;
        for (int k = 0; k < 6; k++) begin
            rd(8'(k), d);
            chk(d, exp_b(k), "counter byte");
        end
    endtask : regs

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    initial begin
        #600000;
        mismatches++;
        $display("MISMATCH %0t watchdog expired", $time);
        summarize();
    end

    initial begin : main
        logic [7:0] d, b, st, mk;
        for (int c = 0; c < 6; c++) begin
            ctrl <= 8'(CFG[c][0]);
            zb <= CFG[c][1];
            lost_en <= CFG[c][2];
            sat <= CFG[c][3];
            nlen <= CFG[c][0] == 128 ? BPS / `E1PC_FAST_DIV : BPS;
            rst <= 1'b1;
            repeat (10) @(posedge clk);
            rst <= 1'b0;
            wr(`E1PC_OFF_CTRL, 8'(CFG[c][0]));
            rd(`E1PC_OFF_CTRL, d);
            chk(d, 8'(CFG[c][0]), "control readback");
            wait_tick();
            repeat (3) begin
                wait_tick();
                repeat (2) @(posedge clk);
                regs();
                // Read-only place must ignore writes
                wr(`E1PC_OFF_VC_LO, 8'h5a);
                repeat (nlen) @(posedge clk);
                regs();
            end
            $display("counter test %0d done", c);
        end
        // Clock enable low must freeze the sticky status
        @(posedge clk);
        ce <= 1'b0;
        rx_ev <= 8'h01;
        @(posedge clk);
        ce <= 1'b1;
        rx_ev <= 8'h00;
        rd(`E1PC_OFF_RX_STATUS, d);
        chk(d, 8'h00, "status frozen by enable");
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd(`E1PC_OFF_RX_MASK, d);
        chk(d, `E1PC_MASK_RST, "rx mask reset");
        rd(`E1PC_OFF_FT_MASK, d);
        chk(d, `E1PC_MASK_RST, "ft mask reset");
        rd(8'h40, d);
        chk(d, 8'h00, "unmapped read");
        // Write then read with no idle cycle between the strobes
        @(posedge clk);
        addr <= `E1PC_OFF_RX_MASK;
        wdata <= 8'h5c;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, 8'h5c, "mask back to back");
        for (int i = 0; i < 16; i++) begin
            if (i == 12) continue;
            st = i < 8 ? `E1PC_OFF_RX_STATUS : `E1PC_OFF_FT_STATUS;
            mk = i < 8 ? `E1PC_OFF_RX_MASK : `E1PC_OFF_FT_MASK;
            b = 8'h01 << i[2:0];
            wr(`E1PC_OFF_RX_STATUS, 8'hff);
            wr(`E1PC_OFF_FT_STATUS, 8'hff);
            wr(mk, ~b & 8'hef);
            @(posedge clk);
            rx_ev <= i < 8 ? b : 8'h00;
            ft_ev <= i < 8 ? 8'h00 : b;
            @(posedge clk);
            rx_ev <= 8'h00;
            ft_ev <= 8'h00;
            irq_is(1'b0);
            rd(st, d);
            chk(d & (i < 8 ? 8'hff : 8'hef), b, "sticky status");
            rd(mk, d);
            chk(d, ~b & 8'hef, "mask readback");
            wr(mk, b);
            irq_is(1'b1);
            wr(st, b);
            irq_is(1'b0);
            rd(st, d);
            chk(d & (i < 8 ? 8'hff : 8'hef), 8'h00, "status cleared");
            wr(mk, 8'h00);
        end
        wait_tick();
        wr(`E1PC_OFF_FT_STATUS, 8'hff);
        wr(`E1PC_OFF_FT_MASK, 8'h10);
        irq_is(1'b0);
        wait_tick();
        irq_is(1'b1);
        $display("interrupt test done");
        summarize();
    end
endmodule : e1_perf_counters_irq_masks_tb_top
`default_nettype wire
